// ---- hw/gcc_gain_ctrl.sv ----
/*
  Dual gain code control: two 6-bit gain codes set by a parallel port,
  a three-wire serial port or up/down stepping, chosen by two select pins.
  Assumes all pins other than the serial ones are asynchronous levels,
  held for at least three system clocks between changes.
*/
`default_nettype none
// How it works
// - Select pins choose parallel, serial or up/down
// - Each channel keeps a 6-bit gain code
// - Code zero is 20 dB, 0.5 dB per step
// - Parallel mode uses six bits plus hold
// - Transparent hold follows bits; held keeps code
// - Hold pin high blocks any gain change
// - Serial port: data pin, clock, two selects
// - Serial word: gain, step, spare, read flag
// - Both selects low write both channels
// - Write loads gain and step; read ignores
// - After read flag, sixteen clocks drive readback
// - Fast attack lowers gain from present code
// - Step bits pick 2, 4, 8, 16 dB
// - Direction high raises gain one step
// - Direction low lowers gain one step
// - Step pins pick 1, 2, 4, 8 codes
// - Stepping saturates at both code ends
// - Direction flip within pulse loads code 63
// - Performance pin and per-channel power pins
// - Shared pins routed by selected mode
module gcc_gain_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       spiClk,
  input  wire logic       ifaceSelLo,
  input  wire logic       ifaceSelHi,
  input  wire logic       perfSelect,
  input  wire logic       chanAPowerOn,
  input  wire logic       chanBPowerOn,
  input  wire logic       chanAHold,
  input  wire logic       chanBHold,
  input  wire logic [5:0] chanAParGain,
  input  wire logic [5:0] chanBParGain,
  input  wire logic       updnStepHi,
  input  wire logic       updnStepLo,
  input  wire logic       chanASelectN,
  input  wire logic       chanBSelectN,
  input  wire logic       sdioIn,
  output logic            sdioOut,
  output logic            sdioOe,
  output logic      [5:0] chanAGain,
  output logic      [5:0] chanBGain,
  output logic      [6:0] chanAGainHalfDb,
  output logic      [6:0] chanBGainHalfDb,
  output logic            chanAEnable,
  output logic            chanBEnable,
  output logic            perfHigh
);
  import gcc_pkg::*;

  localparam int SYNC_W = 22;

  typedef struct packed {
    logic [1:0][GAIN_W-1:0] gain;
    logic [1:0][1:0]        atkStep;
    logic [1:0]             prevClk;
    logic [1:0]             dirAtRise;
    logic [1:0]             prevAtk;
    logic                   lastTog;
    logic [1:0][6:0]        halfDb;
    logic [1:0]             enable;
    logic                   perfHigh;
  } gcc_state_t;

  gcc_state_t             st;
  gcc_state_t             next_st;
  logic [SYNC_W-1:0]      rawPins;
  logic [SYNC_W-1:0]      syncPins;
  logic                   wrTog;
  logic [WORD_W-1:0]      wordHold;
  logic [1:0]             wordTo;
  logic [WORD_W-1:0]      readWordA;
  logic [WORD_W-1:0]      readWordB;
  gcc_mode_t              mode;
  logic                   newWord;
  logic [1:0][GAIN_W-1:0] parGain;
  logic [1:0]             hold;
  logic [1:0]             power;
  logic [1:0]             stepClk;
  logic [1:0]             stepDir;
  logic [1:0]             atkTrig;
  logic [1:0]             riseEdge;
  logic [1:0]             fallEdge;
  logic [1:0]             atkRise;
  logic [1:0]             wordHit;
  logic [1:0][GAIN_W-1:0] atkDelta;
  logic [1:0][GAIN_W-1:0] candGain;
  logic [GAIN_W-1:0]      updnDelta;

  function automatic logic [GAIN_W-1:0] satAdd(input logic [GAIN_W-1:0] code,
                                               input logic [GAIN_W-1:0] delta);
    logic [GAIN_W:0] sum;
    sum = {1'b0, code} + {1'b0, delta};
    return sum[GAIN_W] ? GAIN_MAX : sum[GAIN_W-1:0];
  endfunction

  function automatic logic [GAIN_W-1:0] satSub(input logic [GAIN_W-1:0] code,
                                               input logic [GAIN_W-1:0] delta);
    return (code < delta) ? GAIN_MIN : code - delta;
  endfunction

  function automatic logic [6:0] toHalfDb(input logic [GAIN_W-1:0] code);
    return TOP_HALF_DB - {1'b0, code};
  endfunction

  // Every pin but the serial ones, and the write toggle from the serial clock, is synchronised
  assign rawPins = {wrTog, updnStepHi, updnStepLo, chanBParGain, chanAParGain,
                    chanBHold, chanAHold, chanBPowerOn, chanAPowerOn,
                    perfSelect, ifaceSelHi, ifaceSelLo};

  gcc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (rawPins),
    .q     (syncPins)
  );

  // Readback reports the present code and step of each channel
  assign readWordA = {1'b0, 7'h00, st.atkStep[0], st.gain[0]};
  assign readWordB = {1'b0, 7'h00, st.atkStep[1], st.gain[1]};

  gcc_spi_link u_link (
    .spiClk       (spiClk),
    .rst_n        (rst_n),
    .chanASelectN (chanASelectN),
    .chanBSelectN (chanBSelectN),
    .sdioIn       (sdioIn),
    .readWordA    (readWordA),
    .readWordB    (readWordB),
    .sdioOut      (sdioOut),
    .sdioOe       (sdioOe),
    .wrTog        (wrTog),
    .wordHold     (wordHold),
    .wordToA      (wordTo[0]),
    .wordToB      (wordTo[1])
  );

  always_comb begin
    mode       = gcc_decode_mode(syncPins[1], syncPins[0]);
    power      = syncPins[4:3];
    hold       = syncPins[6:5];
    parGain[0] = syncPins[12:7];
    parGain[1] = syncPins[18:13];
    updnDelta  = UPDN_BASE << syncPins[20:19];
    newWord    = syncPins[21] ^ st.lastTog;
    for (int c = 0; c < 2; c++) begin
      stepDir[c]  = parGain[c][PIN_DIR];
      stepClk[c]  = parGain[c][PIN_CLK];
      atkTrig[c]  = parGain[c][PIN_ATTACK];
      riseEdge[c] = stepClk[c] & ~st.prevClk[c];
      fallEdge[c] = ~stepClk[c] & st.prevClk[c];
      atkRise[c]  = atkTrig[c] & ~st.prevAtk[c];
      wordHit[c]  = newWord & wordTo[c] & ~wordHold[RW_BIT];
      atkDelta[c] = ATTACK_BASE << st.atkStep[c];
    end
  end

  always_comb begin
    next_st          = st;
    next_st.lastTog  = syncPins[21];
    next_st.enable   = power;
    next_st.perfHigh = syncPins[2];
    for (int c = 0; c < 2; c++) begin
      candGain[c]         = st.gain[c];
      next_st.prevClk[c]  = stepClk[c];
      next_st.prevAtk[c]  = atkTrig[c];
      if (riseEdge[c]) begin
        next_st.dirAtRise[c] = stepDir[c];
      end
      unique case (mode)
        MODE_PARALLEL: begin
          candGain[c] = parGain[c];
        end
        MODE_SERIAL: begin
          if (wordHit[c]) begin
            candGain[c]        = wordHold[GAIN_LSB +: GAIN_W];
            next_st.atkStep[c] = wordHold[STEP_LSB +: 2];
          end else if (atkRise[c]) begin
            candGain[c] = satAdd(st.gain[c], atkDelta[c]);
          end
        end
        MODE_UPDOWN: begin
          if (fallEdge[c]) begin
            if (stepDir[c] != st.dirAtRise[c]) begin
              candGain[c] = GAIN_RESET;
            end else if (stepDir[c]) begin
              candGain[c] = satSub(st.gain[c], updnDelta);
            end else begin
              candGain[c] = satAdd(st.gain[c], updnDelta);
            end
          end
        end
      endcase
      // A high hold level freezes the code whatever the mode
      if (!hold[c]) begin
        next_st.gain[c] = candGain[c];
      end
      next_st.halfDb[c] = toHalfDb(next_st.gain[c]);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0;
      st.gain[0] <= GAIN_RESET;
      st.gain[1] <= GAIN_RESET;
      st.halfDb  <= {2{TOP_HALF_DB - {1'b0, GAIN_RESET}}};
    end else begin
      st <= next_st;
    end
  end

  assign chanAGain       = st.gain[0];
  assign chanBGain       = st.gain[1];
  assign chanAGainHalfDb = st.halfDb[0];
  assign chanBGainHalfDb = st.halfDb[1];
  assign chanAEnable     = st.enable[0];
  assign chanBEnable     = st.enable[1];
  assign perfHigh        = st.perfHigh;

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_par_follow: assert property (
    mode == MODE_PARALLEL && !hold[0] |=> st.gain[0] == $past(parGain[0]))
    else $error("parallel code not followed");

  a_hold_freeze: assert property (
    hold[1] |=> $stable(st.gain[1]))
    else $error("gain changed while held");

  sequence s_flip_pulse;
    mode == MODE_UPDOWN && !hold[0] && fallEdge[0] && stepDir[0] != st.dirAtRise[0];
  endsequence

  a_updn_reset: assert property (
    s_flip_pulse |=> st.gain[0] == GAIN_RESET)
    else $error("direction flip did not reset code");

  sequence s_up_pulse;
    mode == MODE_UPDOWN && !hold[0] && fallEdge[0] && stepDir[0] && st.dirAtRise[0];
  endsequence

  a_updn_up: assert property (
    s_up_pulse |=> st.gain[0] == (($past(st.gain[0]) < $past(updnDelta)) ?
                                  GAIN_MIN : $past(st.gain[0]) - $past(updnDelta)))
    else $error("up step wrong");

  a_updn_sat: assert property (
    mode == MODE_UPDOWN && !hold[1] && fallEdge[1] && !stepDir[1] && !st.dirAtRise[1]
    && st.gain[1] > GAIN_MAX - updnDelta |=> st.gain[1] == GAIN_MAX)
    else $error("down step did not saturate");

  a_serial_load: assert property (
    mode == MODE_SERIAL && wordHit[1] && !hold[1]
    |=> st.gain[1] == $past(wordHold[GAIN_LSB +: GAIN_W]) && st.atkStep[1] == $past(wordHold[STEP_LSB +: 2]))
    else $error("serial write not loaded");

  // Reads hand nothing over; only writes or attacks move the code
  a_read_ignore: assert property (
    mode == MODE_SERIAL && !wordHit[0] && !atkRise[0]
    |=> $stable(st.gain[0]) && $stable(st.atkStep[0]))
    else $error("serial channel changed without a write or attack");

  a_attack_step: assert property (
    mode == MODE_SERIAL && atkRise[0] && !wordHit[0] && !hold[0]
    |=> st.gain[0] == satAdd($past(st.gain[0]), $past(atkDelta[0])) && st.gain[0] >= $past(st.gain[0]))
    else $error("fast attack step wrong");

  a_half_db: assert property (
    st.halfDb[1] == TOP_HALF_DB - {1'b0, st.gain[1]})
    else $error("gain in half dB does not match code");

  a_power_follow: assert property (
    power[0] ##1 power[0] |=> chanAEnable)
    else $error("channel enable did not follow power pin");

  a_hold_freeze_a: assert property (
    hold[0] |=> $stable(st.gain[0]))
    else $error("channel A gain changed while held");

  a_par_follow_b: assert property (
    mode == MODE_PARALLEL && !hold[1] |=> st.gain[1] == $past(parGain[1]))
    else $error("channel B parallel code not followed");

  sequence s_down_pulse;
    mode == MODE_UPDOWN && !hold[0] && fallEdge[0] && !stepDir[0] && !st.dirAtRise[0];
  endsequence

  a_updn_down: assert property (
    s_down_pulse |=> st.gain[0] == satAdd($past(st.gain[0]), $past(updnDelta)))
    else $error("down step wrong");

  a_updn_floor: assert property (
    s_up_pulse ##0 st.gain[0] < updnDelta |=> st.gain[0] == GAIN_MIN)
    else $error("up step did not stop at code zero");

  a_flip_reset_b: assert property (
    mode == MODE_UPDOWN && !hold[1] && fallEdge[1] && stepDir[1] != st.dirAtRise[1]
    |=> st.gain[1] == GAIN_RESET)
    else $error("channel B direction flip did not reset code");

  // Between pulses the shared pins must not act as parallel bits
  a_updn_quiet: assert property (
    mode == MODE_UPDOWN && !fallEdge[0] |=> $stable(st.gain[0]))
    else $error("gain moved without a step pulse");

  a_serial_load_a: assert property (
    mode == MODE_SERIAL && wordHit[0] && !hold[0]
    |=> st.gain[0] == $past(wordHold[GAIN_LSB +: GAIN_W]))
    else $error("channel A serial write not loaded");

  // Step bits load even under hold, so a later attack uses them
  a_step_load: assert property (
    mode == MODE_SERIAL && wordHit[0] |=> st.atkStep[0] == $past(wordHold[STEP_LSB +: 2]))
    else $error("attack step bits not loaded");

  a_attack_sat: assert property (
    mode == MODE_SERIAL && atkRise[1] && !wordHit[1] && !hold[1]
    && {1'b0, st.gain[1]} + {1'b0, atkDelta[1]} > 7'h3f |=> st.gain[1] == GAIN_MAX)
    else $error("fast attack did not saturate");

  a_chan_apart: assert property (
    mode == MODE_SERIAL && !wordHit[1] && !atkRise[1] |=> $stable(st.gain[1]))
    else $error("channel B gain moved without a cause");

  a_half_db_a: assert property (
    st.halfDb[0] == TOP_HALF_DB - {1'b0, st.gain[0]})
    else $error("channel A half dB does not match code");

  a_enable_track: assert property (
    {chanBEnable, chanAEnable} == $past(power) && perfHigh == $past(syncPins[2]))
    else $error("enable or performance output lags its pin");
endmodule
`default_nettype wire

// ---- hw/gcc_pkg.sv ----
/*
  Shared constants for the dual gain code control block: code range,
  serial word layout, shared pin routing and interface modes.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package gcc_pkg;
  localparam int         GAIN_W      = 6;
  localparam int         WORD_W      = 16;
  localparam logic [5:0] GAIN_MIN    = 6'h00;
  localparam logic [5:0] GAIN_MAX    = 6'h3f;
  localparam logic [5:0] GAIN_RESET  = 6'h3f;
  localparam logic [6:0] TOP_HALF_DB = 7'h28;
  localparam int         GAIN_LSB    = 0;
  localparam int         STEP_LSB    = 6;
  localparam int         RW_BIT      = 15;
  localparam logic [3:0] LAST_BIT    = 4'hf;
  localparam int         PIN_DIR     = 0;
  localparam int         PIN_CLK     = 1;
  localparam int         PIN_ATTACK  = 2;
  localparam logic [5:0] ATTACK_BASE = 6'h04;
  localparam logic [5:0] UPDN_BASE   = 6'h01;

  typedef enum logic [1:0] {MODE_PARALLEL, MODE_SERIAL, MODE_UPDOWN} gcc_mode_t;

  function automatic gcc_mode_t gcc_decode_mode(input logic selHi, input logic selLo);
    if (selHi) begin
      return MODE_UPDOWN;
    end
    return selLo ? MODE_SERIAL : MODE_PARALLEL;
  endfunction
endpackage
`default_nettype wire

// ---- hw/gcc_spi_link.sv ----
/*
  Serial port logic on the serial clock: shifts in 16-bit words, hands
  written words to the system clock by a toggle, and shifts out the
  readback word after a read request.
  Assumes the serial clock only runs while a select is low, and that the
  readback words are quasi-static while a frame runs.
*/
`default_nettype none
module gcc_spi_link (
  input  wire logic                      spiClk,
  input  wire logic                      rst_n,
  input  wire logic                      chanASelectN,
  input  wire logic                      chanBSelectN,
  input  wire logic                      sdioIn,
  input  wire logic [gcc_pkg::WORD_W-1:0] readWordA,
  input  wire logic [gcc_pkg::WORD_W-1:0] readWordB,
  output logic                           sdioOut,
  output logic                           sdioOe,
  output logic                           wrTog,
  output logic      [gcc_pkg::WORD_W-1:0] wordHold,
  output logic                           wordToA,
  output logic                           wordToB
);
  import gcc_pkg::*;

  typedef struct packed {
    logic [3:0]        bitCnt;
    logic [WORD_W-1:0] shiftIn;
    logic [WORD_W-1:0] shiftOut;
    logic              reading;
    logic              oe;
  } gcc_frame_t;

  typedef struct packed {
    logic              tog;
    logic [WORD_W-1:0] word;
    logic              toA;
    logic              toB;
  } gcc_handoff_t;

  gcc_frame_t        fr;
  gcc_frame_t        next_fr;
  gcc_handoff_t      ho;
  gcc_handoff_t      next_ho;
  logic              frameRst_n;
  logic [WORD_W-1:0] fullWord;

  // Raising both selects ends the frame even with the clock stopped
  assign frameRst_n = rst_n & ~(chanASelectN & chanBSelectN);

  always_comb begin
    next_fr        = fr;
    next_ho        = ho;
    fullWord       = {fr.shiftIn[WORD_W-2:0], sdioIn};
    next_fr.bitCnt = fr.bitCnt + 4'h1;
    if (fr.reading) begin
      next_fr.shiftOut = {fr.shiftOut[WORD_W-2:0], 1'b0};
      if (fr.bitCnt == LAST_BIT) begin
        next_fr.reading = 1'b0;
        next_fr.oe      = 1'b0;
      end
    end else begin
      next_fr.shiftIn = fullWord;
      if (fr.bitCnt == LAST_BIT) begin
        if (fullWord[RW_BIT]) begin
          next_fr.reading  = 1'b1;
          next_fr.oe       = 1'b1;
          next_fr.shiftOut = chanASelectN ? readWordB : readWordA;
        end else begin
          next_ho.tog  = ~ho.tog;
          next_ho.word = fullWord;
          next_ho.toA  = ~chanASelectN;
          next_ho.toB  = ~chanBSelectN;
        end
      end
    end
  end

  always_ff @(posedge spiClk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end

  // Kept apart from the frame reset so the toggle survives the frame end
  always_ff @(posedge spiClk or negedge rst_n) begin
    if (!rst_n) begin
      ho <= '0;
    end else begin
      ho <= next_ho;
    end
  end

  assign sdioOut  = fr.shiftOut[WORD_W-1];
  assign sdioOe   = fr.oe;
  assign wrTog    = ho.tog;
  assign wordHold = ho.word;
  assign wordToA  = ho.toA;
  assign wordToB  = ho.toB;

  sequence s_drive_half;
    fr.oe [*8];
  endsequence

  a_read_window: assert property (@(posedge spiClk) disable iff (!frameRst_n)
    $rose(fr.oe) |-> s_drive_half ##1 s_drive_half ##1 !fr.oe)
    else $error("readback drive did not last 16 clocks");

  // Hand-over is seen at the next frame's first edge, past the frame reset
  a_both_load: assert property (@(posedge spiClk) disable iff (!rst_n)
    !fr.reading && fr.bitCnt == LAST_BIT && !fullWord[RW_BIT] && !chanASelectN && !chanBSelectN
    |=> ho.toA && ho.toB && $changed(ho.tog))
    else $error("broadcast write did not reach both channels");

  a_read_no_load: assert property (@(posedge spiClk) disable iff (!frameRst_n)
    !fr.reading && fr.bitCnt == LAST_BIT && fullWord[RW_BIT] |=> $stable(ho.tog) && fr.oe)
    else $error("read request was handed over as a write");
endmodule
`default_nettype wire

// ---- hw/gcc_sync.sv ----
/*
  Two flip-flop synchroniser for a bus of independent levels.
  Assumes each bit is a level that is stable for several clocks.
*/
`default_nettype none
module gcc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import gcc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } gcc_sync_t;

  gcc_sync_t st;
  gcc_sync_t next_st;

  always_comb begin
    next_st.meta   = d;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;
endmodule
`default_nettype wire

// ---- verification/gcc_ctrl_model.sv ----
/*
  Controller model for the serial port; the link clock runs only in frames.
  Assumes the bench resolves the data line from both drivers.
*/
`default_nettype none
module gcc_ctrl_model (
  output var logic  spiClk,
  output var logic  chanASelectN,
  output var logic  chanBSelectN,
  output var logic  sdioDrv,
  input  wire logic sdioLine
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spiClk = 1'b0;
    chanASelectN = 1'b1;
    chanBSelectN = 1'b1;
    sdioDrv = 1'b0;
  end
  task automatic pulse1();
    #7.5 spiClk = 1'b1;
    #7.5 spiClk = 1'b0;
  endtask
  task automatic frame(input logic [1:0] sel, input logic [15:0] w, output logic [15:0] r);
    logic [1:0] s;
    s = (w[15] && sel == 2'b11) ? 2'b01 : sel;
    r = 16'h0000;
    #3.3;
    chanASelectN = ~s[0];
    chanBSelectN = ~s[1];
    #10;
    for (int i = 15; i >= 0; i--) begin
      sdioDrv = w[i];
      pulse1();
    end
    if (w[15]) begin
      // Released line shows the inverse, not a stale bit
      sdioDrv = ~sdioDrv;
      for (int i = 15; i >= 0; i--) begin
        r[i] = sdioLine;
        pulse1();
      end
    end
    #10;
    chanASelectN = 1'b1;
    chanBSelectN = 1'b1;
    sdioDrv = ~sdioDrv;
  endtask
endmodule
`default_nettype wire

// ---- verification/gcc_gain_ctrl_tb.sv ----
/*
  Self-checking bench for the dual gain code control block.
  Assumes the controller model drives the serial pins.
*/
`default_nettype none
module gcc_gain_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import gcc_pkg::*;
  logic        sys_clk, rst_n, ifaceSelLo, ifaceSelHi, perfSelect, chanAPowerOn, chanBPowerOn;
  logic        chanAHold, chanBHold, updnStepHi, updnStepLo, sdioOut, sdioOe, chanAEnable, chanBEnable;
  logic        perfHigh, spiClk, chanASelectN, chanBSelectN, sdioDrv, sdioLine;
  logic [5:0]  chanAParGain, chanBParGain, chanAGain, chanBGain, ga, gb, a, b;
  logic [6:0]  chanAGainHalfDb, chanBGainHalfDb;
  logic [15:0] rdWord;
  int          fail_count, tests_run, cyc;

  assign sdioLine = sdioOe ? sdioOut : sdioDrv;

  gcc_gain_ctrl gcc_gain_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .spiClk(spiClk),
    .ifaceSelLo(ifaceSelLo), .ifaceSelHi(ifaceSelHi), .perfSelect(perfSelect),
    .chanAPowerOn(chanAPowerOn), .chanBPowerOn(chanBPowerOn), .chanAHold(chanAHold),
    .chanBHold(chanBHold), .chanAParGain(chanAParGain), .chanBParGain(chanBParGain),
    .updnStepHi(updnStepHi), .updnStepLo(updnStepLo), .chanASelectN(chanASelectN),
    .chanBSelectN(chanBSelectN), .sdioIn(sdioLine), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .chanAGain(chanAGain), .chanBGain(chanBGain), .chanAGainHalfDb(chanAGainHalfDb),
    .chanBGainHalfDb(chanBGainHalfDb), .chanAEnable(chanAEnable), .chanBEnable(chanBEnable),
    .perfHigh(perfHigh));

  gcc_ctrl_model gcc_ctrl_model_inst (.spiClk(spiClk), .chanASelectN(chanASelectN),
    .chanBSelectN(chanBSelectN), .sdioDrv(sdioDrv), .sdioLine(sdioLine));

  always #12.5 sys_clk = ~sys_clk;

  // Whole run needs under two thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  function automatic logic [5:0] satAdd(input logic [5:0] c, input logic [6:0] d);
    logic [6:0] s;
    s = {1'b0, c} + d;
    return (s > 7'h3f) ? 6'h3f : s[5:0];
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Outputs are read mid-cycle, clear of the edge that launches them
  task automatic chkGain(input logic [5:0] ea, input logic [5:0] eb);
    @(negedge sys_clk);
    tests_run++;
    if (chanAGain !== ea || chanBGain !== eb || chanAGainHalfDb !== 7'h28 - {1'b0, ea}
        || chanBGainHalfDb !== 7'h28 - {1'b0, eb}) begin
      fail_count++;
      $display("BAD %0t gain %h %h exp %h %h", $time, chanAGain, chanBGain, ea, eb);
    end
  endtask

  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    @(negedge sys_clk);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic setMode(input logic [1:0] m);
    @(posedge sys_clk);
    ifaceSelHi <= m[1];
    ifaceSelLo <= m[0];
    wt(4);
  endtask

  task automatic pins(input logic [5:0] pa, input logic [5:0] pb);
    @(posedge sys_clk);
    chanAParGain <= pa;
    chanBParGain <= pb;
    wt(4);
  endtask

  task automatic spi(input logic [1:0] sel, input logic [15:0] w);
    gcc_ctrl_model_inst.frame(sel, w, rdWord);
    wt(8);
  endtask

  // Step clock is bit 1, direction bit 0 of the shared pins
  task automatic pulse(input logic ch, input logic d0, input logic d1, input logic [1:0] st);
    logic [5:0] c;
    logic [5:0] d;
    c = ch ? gb : ga;
    d = 6'h01 << st;
    @(posedge sys_clk);
    {updnStepHi, updnStepLo} <= st;
    pins(ch ? 6'h00 : {5'h00, d0}, ch ? {5'h00, d0} : 6'h00);
    pins(ch ? 6'h00 : {5'h01, d0}, ch ? {5'h01, d0} : 6'h00);
    pins(ch ? 6'h00 : {5'h01, d1}, ch ? {5'h01, d1} : 6'h00);
    pins(ch ? 6'h00 : {5'h00, d1}, ch ? {5'h00, d1} : 6'h00);
    if (ch ? chanBHold : chanAHold) c = c;
    else if (d0 !== d1) c = 6'h3f;
    else if (d0) c = (c < d) ? 6'h00 : c - d;
    else c = satAdd(c, {1'b0, d});
    if (ch) gb = c;
    else ga = c;
    chkGain(ga, gb);
  endtask

  initial begin
    void'($urandom(65021));
    {sys_clk, rst_n, ifaceSelLo, ifaceSelHi, perfSelect, chanAPowerOn, chanBPowerOn} = '0;
    {chanAHold, chanBHold, updnStepHi, updnStepLo} = '0;
    {chanAParGain, chanBParGain, cyc, fail_count, tests_run} = '0;
    wt(14);
    chkGain(6'h3f, 6'h3f);
    chkWord({12'h000, chanAEnable, chanBEnable, perfHigh, sdioOe}, 16'h0000);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(4);
    repeat (4) begin
      a = 6'($urandom);
      @(posedge sys_clk);
      {chanBPowerOn, chanAPowerOn, perfSelect} <= a[2:0];
      wt(4);
      chkWord({13'h0000, chanBEnable, chanAEnable, perfHigh}, {13'h0000, a[2:0]});
    end
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 6'h00 : 6'($urandom);
      b = (i == 0) ? 6'h3f : 6'($urandom);
      pins(a, b);
      chkGain(a, b);
    end
    @(posedge sys_clk);
    chanAHold <= 1'b1;
    wt(4);
    pins(~a, ~b);
    chkGain(a, ~b);
    @(posedge sys_clk);
    chanAHold <= 1'b0;
    wt(4);
    chkGain(~a, ~b);
    pins(6'h00, 6'h00);
    setMode(2'b01);
    pins(6'h03, 6'h03);
    chkGain(6'h00, 6'h00);
    pins(6'h00, 6'h00);
    gb = 6'h00;
    for (int s = 0; s < 4; s++) begin
      ga = (s == 3) ? 6'h30 : 6'($urandom);
      spi(2'b01, {1'b0, 7'($urandom), 2'(s), ga});
      chkGain(ga, gb);
      pins(6'h04, 6'h00);
      ga = satAdd(ga, 7'h04 << s);
      chkGain(ga, gb);
      pins(6'h00, 6'h00);
      spi(2'b01, {1'b1, 15'($urandom)});
      chkWord(rdWord, {8'h00, 2'(s), ga});
      chkGain(ga, gb);
    end
    ga = 6'($urandom);
    spi(2'b11, {8'h00, 2'b01, ga});
    gb = 6'($urandom);
    chkGain(ga, ga);
    spi(2'b10, {8'h7f, 2'b10, gb});
    pins(6'h00, 6'h04);
    gb = satAdd(gb, 7'h10);
    chkGain(ga, gb);
    pins(6'h00, 6'h00);
    spi(2'b10, 16'hffff);
    chkWord(rdWord, {8'h00, 2'b10, gb});
    @(posedge sys_clk);
    chanAHold <= 1'b1;
    spi(2'b01, {8'h00, 2'b00, ~ga});
    chkGain(ga, gb);
    @(posedge sys_clk);
    chanAHold <= 1'b0;
    setMode(2'b10);
    pulse(1'b0, 1'b1, 1'b0, 2'b00);
    pulse(1'b1, 1'b0, 1'b1, 2'b01);
    pulse(1'b0, 1'b0, 1'b0, 2'($urandom));
    for (int i = 0; i < 32; i++) begin
      if (i == 16) setMode(2'b11);
      a = 6'($urandom);
      pulse(i[0], (i < 16) ? 1'b1 : a[0], (i < 16) ? 1'b1 : a[0], (i < 16) ? 2'b11 : a[2:1]);
    end
    @(posedge sys_clk);
    chanBHold <= 1'b1;
    wt(4);
    pulse(1'b1, 1'b0, 1'b0, 2'b11);
    tally_and_finish();
  end
endmodule
`default_nettype wire
